//--- dv/pmca_i2c_host.sv
// serial bus host model driving clock and data lines of the monitor
`include "pmca_regs.svh"

module pmca_i2c_host #(
    parameter int HALF = 16
) (
    // clock and slave data enable
    input wire logic ref_clk,
    input wire logic sdaOe_n,
    // bus lines as seen by the slave
    output logic scl,
    output logic sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sdaDrv;
    // pulled-up data line: either party may pull it low
    assign sdaLine = sdaDrv & sdaOe_n;
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hold
    // data moves only well after clock low so no false start or stop is seen
    task automatic xbit(input logic b, output logic r);
        scl = 1'b0;
        hold(4);
        sdaDrv = b;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        r = sdaLine;
    endtask : xbit
    task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(m, a);
    endtask : xbyte
    // start: data high then falling under clock high; stop: data low then rising
    task automatic frame(input logic open);
        scl = 1'b0;
        hold(4);
        sdaDrv = open;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sdaDrv = !open;
        hold(HALF);
    endtask : frame
    task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] w,
            output logic nak);
        logic [7:0] q;
        logic [3:0] a;
        frame(1'b1);
        xbyte({adr, 1'b0}, 1'b1, q, a[0]);
        xbyte(cmd, 1'b1, q, a[1]);
        xbyte(w[7:0], 1'b1, q, a[2]);
        xbyte(w[15:8], 1'b1, q, a[3]);
        frame(1'b0);
        nak = |a;
    endtask : write_word
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] w, output logic nak);
        logic [7:0] q;
        logic [3:0] a;
        frame(1'b1);
        xbyte({`PMCA_SLAVE_ADDR, 1'b0}, 1'b1, q, a[0]);
        xbyte(cmd, 1'b1, q, a[1]);
        frame(1'b1);
        xbyte({`PMCA_SLAVE_ADDR, 1'b1}, 1'b1, q, a[2]);
        xbyte(8'hff, 1'b0, w[7:0], a[3]);
        xbyte(8'hff, 1'b1, w[15:8], a[3]);
        frame(1'b0);
        nak = |a[2:0];
    endtask : read_word
endmodule : pmca_i2c_host

//--- dv/pmca_power_monitor_chk.sv
// port checker of the power monitor config block
module pmca_power_monitor_chk #(
    parameter int INT_MS_CYCLES = 25000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // serial bus
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe_n,
    // alert and control
    input wire logic alertOut,
    input wire logic alertOe_n,
    input wire logic shutdownMode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    int ackAge;
    int upCnt;
    // age since the slave last pulled data low, and cycles since reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ackAge <= 100;
            upCnt <= 0;
        end else begin
            ackAge <= !sdaOe_n ? 0 : (ackAge < 100 ? ackAge + 1 : ackAge);
            upCnt <= (upCnt < INT_MS_CYCLES) ? upCnt + 1 : upCnt;
        end
    end
    // ==========
    // properties
    property p_sda_low; sdaOut == 1'b0; endproperty
    property p_alert_low; alertOut == 1'b0; endproperty
    property p_reset_quiet; $rose(arst_n) |-> alertOe_n && sdaOe_n && !shutdownMode; endproperty
    property p_ack_scl_low; $fell(sdaOe_n) |-> !sclIn; endproperty
    property p_release_scl_low; $rose(sdaOe_n) |-> !sclIn; endproperty
    property p_cfg_at_ack; $changed(shutdownMode) |-> ackAge < 8; endproperty
    property p_shut_quiet;
        shutdownMode && $past(shutdownMode, 2) && alertOe_n |=> alertOe_n;
    endproperty
    property p_no_early; upCnt < INT_MS_CYCLES |-> alertOe_n; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda data not low");
    a_alert_low: assert property (p_alert_low) else $error("alert data not low");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("sda pulled in clock high");
    a_release_scl_low: assert property (p_release_scl_low) else $error("sda freed in clock high");
    a_cfg_at_ack: assert property (p_cfg_at_ack) else $error("shutdown moved off ack");
    a_shut_quiet: assert property (p_shut_quiet) else $error("alert during shutdown");
    a_no_early: assert property (p_no_early) else $error("alert before first interval");
    c_alert: cover property ($fell(alertOe_n));
    c_shutdown: cover property ($rose(shutdownMode));
    c_ack: cover property ($fell(sdaOe_n));
endmodule : pmca_power_monitor_chk

bind pmca_power_monitor pmca_power_monitor_chk #(.INT_MS_CYCLES(INT_MS_CYCLES)) u_chk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sclIn(sclIn),
    .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n),
    .alertOut(alertOut),
    .alertOe_n(alertOe_n),
    .shutdownMode(shutdownMode)
);

//--- dv/pmca_power_monitor_tb.sv
// self-checking bench of the power monitor config block
`include "pmca_regs.svh"

module pmca_power_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADR = `PMCA_SLAVE_ADDR;
    localparam logic [2:0] TE = 3'b101;
    logic ref_clk, arst_n, external_clock_input, sclIn, sdaIn;
    logic sdaOut, sdaOe_n, alertOut, alertOe_n, shutdownMode, nak;
    logic signed [15:0] sampleVoltage, sampleCurrent, samplePower;
    logic [15:0] lfsr, rd, cfg, want, seenVal, e;
    logic [15:0] tv[3];
    logic [6:0] thr;
    logic [7:0] cmds[3];
    logic [15:0] expV[$];
    string expN[$], n;
    int fail_count, checked;
    event seen;
    pmca_power_monitor #(.INT_MS_CYCLES(20), .EXT_MS_CYCLES(25)) DUT (
        .ref_clk, .arst_n, .external_clock_input, .sclIn, .sdaIn, .sdaOut, .sdaOe_n,
        .sampleVoltage, .sampleCurrent, .samplePower, .alertOut, .alertOe_n, .shutdownMode
    );
    pmca_i2c_host host (.ref_clk(ref_clk), .sdaOe_n(sdaOe_n), .scl(sclIn), .sdaLine(sdaIn));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        external_clock_input = 1'b0;
        #7;
        forever #16 external_clock_input = ~external_clock_input;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic chk(input string name, input logic [15:0] ev, input logic [15:0] v);
        expN.push_back(name);
        expV.push_back(ev);
        seenVal = v;
        -> seen;
        @(negedge ref_clk);
    endtask : chk
    task automatic print_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ==========
    // result watcher
    initial begin
        forever begin
            @(seen);
            e = expV.pop_front();
            n = expN.pop_front();
            checked++;
            if (seenVal !== e) begin
                $display("Error %s expected %h seen %h", n, e, seenVal);
                fail_count++;
            end
        end
    end
    initial begin
        #3200000;
        fail_count++;
        print_verdict();
    end
    // ==========
    // main sequence
    initial begin
        arst_n = 1'b0;
        lfsr = 16'h000f;
        {sampleVoltage, sampleCurrent, samplePower} = '0;
        cmds = '{`PMCA_CMD_READ_VOLTAGE, `PMCA_CMD_READ_CURRENT, `PMCA_CMD_READ_POWER};
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        host.hold(8);
        host.read_word(`PMCA_CMD_CONFIG, rd, nak);
        chk("config reset", `PMCA_CFG_RESET, rd);
        for (int s = 0; s < 3; s++) begin
            lfsr = lfsr_next(lfsr);
            samplePower = lfsr;
            lfsr = lfsr_next(lfsr);
            sampleVoltage = lfsr;
            lfsr = lfsr_next(lfsr);
            sampleCurrent = lfsr;
            // voltage pass runs from the external tick
            cfg = {7'h00, 1'b0, s[1:0], s == 1, 1'b0, 4'h3};
            host.write_word(ADR, `PMCA_CMD_CONFIG, cfg, nak);
            chk("write ack", 16'h0000, {15'h0000, nak});
            host.hold(400);
            want = (s == 0) ? samplePower : ((s == 1) ? sampleVoltage : sampleCurrent);
            foreach (cmds[k]) begin
                host.read_word(cmds[k], rd, nak);
                chk("output", want, rd);
            end
            host.read_word(`PMCA_CMD_CONFIG, rd, nak);
            chk("config", cfg, rd);
        end
        host.write_word(ADR, `PMCA_CMD_CONFIG, 16'h0008, nak);
        host.hold(400);
        host.read_word(`PMCA_CMD_READ_POWER, rd, nak);
        chk("alert released", 16'h0001, {15'h0000, alertOe_n});
        for (int i = 0; i < 6000 && alertOe_n !== 1'b0; i++) begin
            host.hold(1);
        end
        chk("alert new data", 16'h0000, {15'h0000, alertOe_n});
        host.read_word(`PMCA_CMD_READ_CURRENT, rd, nak);
        chk("alert released", 16'h0001, {15'h0000, alertOe_n});
        lfsr = lfsr_next(lfsr);
        thr = {1'b0, lfsr[5:0]} + 7'h01;
        tv = '{{7'h00, thr, 2'b11}, {7'h00, thr + 7'h01, 2'b00}, 16'hc000};
        cfg = {thr, 1'b1, `PMCA_QTY_VOLTAGE, 2'b00, 4'h0};
        host.write_word(ADR, `PMCA_CMD_CONFIG, cfg, nak);
        // the running 256 ms interval must end before voltage and N=0 take hold
        host.hold(5300);
        foreach (tv[k]) begin
            sampleVoltage = tv[k];
            host.hold(100);
            chk("alert threshold", {15'h0000, TE[k]}, {15'h0000, alertOe_n});
        end
        for (int b = 0; b < 2; b++) begin
            host.write_word(ADR, `PMCA_CMD_CONFIG, {11'h000, b == 0, 4'h0}, nak);
            chk("shutdown", {15'h0000, b == 0}, {15'h0000, shutdownMode});
        end
        host.write_word(ADR ^ 7'h01, `PMCA_CMD_CONFIG, 16'h0001, nak);
        chk("foreign address", 16'h0001, {15'h0000, nak});
        host.read_word(8'h00, rd, nak);
        chk("unknown command", 16'h0000, rd);
        host.read_word(`PMCA_CMD_CONFIG, rd, nak);
        chk("config kept", 16'h0000, rd);
        host.hold(4);
        print_verdict();
    end
endmodule : pmca_power_monitor_tb

//--- hw/pmca_pkg.sv
// types of the power monitor config block
package pmca_pkg;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_CMD,
        LINK_WRDATA,
        LINK_RDDATA,
        LINK_SLAVE_ACK,
        LINK_MASTER_ACK
    } pmca_link_state_t;

endpackage : pmca_pkg

//--- hw/pmca_power_monitor.sv
// serial bus slave, configuration register, averaging and alert logic of the power monitor
`include "pmca_regs.svh"

module pmca_power_monitor
    import pmca_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `PMCA_SLAVE_ADDR,
    parameter int INT_MS_CYCLES = `PMCA_INT_MS_CYCLES,
    parameter int EXT_MS_CYCLES = `PMCA_EXT_MS_CYCLES
) (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic external_clock_input,
    // serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    // measurement front end samples, ref_clk domain
    input wire logic signed [15:0] sampleVoltage,
    input wire logic signed [15:0] sampleCurrent,
    input wire logic signed [15:0] samplePower,
    // alert pin and front end control
    output logic alertOut,
    output logic alertOe_n,
    output logic shutdownMode
);

    function automatic logic signed [15:0] pick_sample(input logic [1:0] sel,
            input logic signed [15:0] v, input logic signed [15:0] i,
            input logic signed [15:0] p);
        unique case (sel)
            `PMCA_QTY_VOLTAGE: pick_sample = v;
            `PMCA_QTY_CURRENT: pick_sample = i;
            default: pick_sample = p;
        endcase
    endfunction : pick_sample

    function automatic logic [3:0] clamp_avg(input logic [3:0] n);
        clamp_avg = (n > `PMCA_AVG_MAX) ? `PMCA_AVG_MAX : n;
    endfunction : clamp_avg

    // ==========================================================
    // pin synchronisers
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclF;
    logic sdaF;
    logic sclPrev;
    logic sdaPrev;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
            sclF <= 1'b1;
            sdaF <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[1:0], sclIn};
            sdaSync <= {sdaSync[1:0], sdaIn};
            if (sclSync[1] == sclSync[2]) begin
                sclF <= sclSync[2];
            end
            if (sdaSync[1] == sdaSync[2]) begin
                sdaF <= sdaSync[2];
            end
            sclPrev <= sclF;
            sdaPrev <= sdaF;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    assign sclRise = sclF && !sclPrev;
    assign sclFall = !sclF && sclPrev;
    assign startCond = sclF && sclPrev && sdaPrev && !sdaF;
    assign stopCond = sclF && sclPrev && !sdaPrev && sdaF;

    // ==========================================================
    // serial bus slave and configuration register
    pmca_link_state_t state, next_state, ackNext, next_ackNext;
    logic [2:0] bitCnt, next_bitCnt;
    logic [7:0] shift, next_shift;
    logic [7:0] cmd, next_cmd;
    logic [7:0] wrLow, next_wrLow;
    logic [15:0] txWord, next_txWord;
    logic [15:0] cfgWord, next_config;
    logic byteDone, next_byteDone;
    logic byteIdx, next_byteIdx;
    logic masterAck, next_masterAck;
    logic outRead, next_outRead;
    logic next_sdaOe_n;
    logic [15:0] outReg;
    logic [7:0] txByte;

    assign txByte = next_byteIdx ? txWord[15:8] : txWord[7:0];

    always_comb begin
        next_state = state;
        next_ackNext = ackNext;
        next_bitCnt = bitCnt;
        next_shift = shift;
        next_cmd = cmd;
        next_wrLow = wrLow;
        next_txWord = txWord;
        next_config = cfgWord;
        next_byteDone = byteDone;
        next_byteIdx = byteIdx;
        next_masterAck = masterAck;
        next_outRead = 1'b0;
        next_sdaOe_n = sdaOe_n;
        if (startCond) begin
            next_state = LINK_ADDR;
            next_bitCnt = 3'h0;
            next_byteDone = 1'b0;
            next_byteIdx = 1'b0;
            next_sdaOe_n = 1'b1;
        end else if (stopCond) begin
            next_state = LINK_IDLE;
            next_sdaOe_n = 1'b1;
        end else if (sclRise) begin
            unique case (state)
                LINK_ADDR, LINK_CMD, LINK_WRDATA, LINK_RDDATA: begin
                    if (state != LINK_RDDATA) begin
                        next_shift = {shift[6:0], sdaF};
                    end
                    next_bitCnt = bitCnt + 3'h1;
                    next_byteDone = (bitCnt == 3'h7);
                end
                LINK_MASTER_ACK: begin
                    next_masterAck = !sdaF;
                    // full word clocked out counts as a read of the output register
                    next_outRead = byteIdx && (cmd != `PMCA_CMD_CONFIG);
                end
                default: ;
            endcase
        end else if (sclFall) begin
            unique case (state)
                LINK_ADDR: begin
                    if (byteDone) begin
                        next_byteDone = 1'b0;
                        if (shift[7:1] == SLAVE_ADDR) begin
                            next_sdaOe_n = 1'b0;
                            next_state = LINK_SLAVE_ACK;
                            next_ackNext = shift[0] ? LINK_RDDATA : LINK_CMD;
                            unique case (cmd)
                                `PMCA_CMD_CONFIG: next_txWord = cfgWord;
                                `PMCA_CMD_READ_VOLTAGE, `PMCA_CMD_READ_CURRENT,
                                `PMCA_CMD_READ_POWER: next_txWord = outReg;
                                default: next_txWord = 16'h0000;
                            endcase
                        end else begin
                            next_state = LINK_IDLE;
                        end
                    end
                end
                LINK_CMD: begin
                    if (byteDone) begin
                        next_byteDone = 1'b0;
                        next_cmd = shift;
                        next_sdaOe_n = 1'b0;
                        next_state = LINK_SLAVE_ACK;
                        next_ackNext = LINK_WRDATA;
                    end
                end
                LINK_WRDATA: begin
                    if (byteDone) begin
                        next_byteDone = 1'b0;
                        next_byteIdx = !byteIdx;
                        if (!byteIdx) begin
                            next_wrLow = shift;
                        end else if (cmd == `PMCA_CMD_CONFIG) begin
                            next_config = {shift, wrLow};
                        end
                        next_sdaOe_n = 1'b0;
                        next_state = LINK_SLAVE_ACK;
                        next_ackNext = LINK_WRDATA;
                    end
                end
                LINK_SLAVE_ACK: begin
                    next_bitCnt = 3'h0;
                    next_state = ackNext;
                    next_sdaOe_n = 1'b1;
                    if (ackNext == LINK_RDDATA) begin
                        next_byteIdx = 1'b0;
                        next_sdaOe_n = txByte[7];
                        next_shift = {txByte[6:0], 1'b0};
                    end
                end
                LINK_RDDATA: begin
                    if (byteDone) begin
                        next_byteDone = 1'b0;
                        next_sdaOe_n = 1'b1;
                        next_state = LINK_MASTER_ACK;
                    end else begin
                        next_sdaOe_n = shift[7];
                        next_shift = {shift[6:0], 1'b0};
                    end
                end
                LINK_MASTER_ACK: begin
                    if (masterAck) begin
                        next_byteIdx = !byteIdx;
                        next_bitCnt = 3'h0;
                        next_sdaOe_n = txByte[7];
                        next_shift = {txByte[6:0], 1'b0};
                        next_state = LINK_RDDATA;
                    end else begin
                        next_state = LINK_IDLE;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= LINK_IDLE;
            ackNext <= LINK_IDLE;
            bitCnt <= 3'h0;
            shift <= 8'h00;
            cmd <= 8'h00;
            wrLow <= 8'h00;
            txWord <= 16'h0000;
            cfgWord <= `PMCA_CFG_RESET;
            byteDone <= 1'b0;
            byteIdx <= 1'b0;
            masterAck <= 1'b0;
            outRead <= 1'b0;
            sdaOe_n <= 1'b1;
            sdaOut <= 1'b0;
        end else begin
            state <= next_state;
            ackNext <= next_ackNext;
            bitCnt <= next_bitCnt;
            shift <= next_shift;
            cmd <= next_cmd;
            wrLow <= next_wrLow;
            txWord <= next_txWord;
            cfgWord <= next_config;
            byteDone <= next_byteDone;
            byteIdx <= next_byteIdx;
            masterAck <= next_masterAck;
            outRead <= next_outRead;
            sdaOe_n <= next_sdaOe_n;
            sdaOut <= 1'b0;
        end
    end

    // ==========================================================
    // external clock domain: millisecond toggle
    logic [31:0] extCnt;
    logic extTog;

    always_ff @(posedge external_clock_input or negedge arst_n) begin
        if (!arst_n) begin
            extCnt <= 32'h0;
            extTog <= 1'b0;
        end else if (extCnt == 32'(EXT_MS_CYCLES - 1)) begin
            extCnt <= 32'h0;
            extTog <= !extTog;
        end else begin
            extCnt <= extCnt + 32'h1;
        end
    end

    // ==========================================================
    // millisecond tick selection and averaging
    logic [2:0] togSync;
    logic togSeen;
    logic [31:0] intCnt, next_intCnt;
    logic msTick;
    logic [3:0] actN, next_actN;
    logic [1:0] actSel, next_actSel;
    logic [8:0] tickCnt, next_tickCnt;
    logic signed [24:0] acc, next_acc;
    logic signed [24:0] accSum;
    logic [15:0] next_outReg;
    logic newData, next_newData;
    logic extTick;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            togSync <= 3'h0;
            togSeen <= 1'b0;
        end else begin
            togSync <= {togSync[1:0], extTog};
            if (togSync[1] == togSync[2]) begin
                togSeen <= togSync[2];
            end
        end
    end

    assign extTick = (togSync[1] == togSync[2]) && (togSync[2] != togSeen);
    // internal tick at the end of a full millisecond, never straight out of reset
    assign msTick = cfgWord[`PMCA_EXTERNAL_CLOCK_INPUT_BIT] ? extTick :
        (intCnt == 32'(INT_MS_CYCLES - 1));
    assign accSum = acc + 25'(pick_sample(actSel, sampleVoltage, sampleCurrent, samplePower));

    always_comb begin
        next_intCnt = (intCnt == 32'(INT_MS_CYCLES - 1)) ? 32'h0 : intCnt + 32'h1;
        next_actN = actN;
        next_actSel = actSel;
        next_tickCnt = tickCnt;
        next_acc = acc;
        next_outReg = outReg;
        next_newData = 1'b0;
        if (cfgWord[`PMCA_SHUTDOWN_BIT]) begin
            next_acc = 25'h0;
            next_tickCnt = 9'h0;
            next_actN = clamp_avg(cfgWord[`PMCA_AVG_MSB:`PMCA_AVG_LSB]);
            next_actSel = cfgWord[`PMCA_SEL_MSB:`PMCA_SEL_LSB];
        end else if (msTick) begin
            if (tickCnt + 9'h1 == (9'h1 << actN)) begin
                next_outReg = 16'(accSum >>> actN);
                next_newData = 1'b1;
                next_acc = 25'h0;
                next_tickCnt = 9'h0;
                // settings take hold at an interval boundary, or at once while shutdown is set
                next_actN = clamp_avg(cfgWord[`PMCA_AVG_MSB:`PMCA_AVG_LSB]);
                next_actSel = cfgWord[`PMCA_SEL_MSB:`PMCA_SEL_LSB];
            end else begin
                next_acc = accSum;
                next_tickCnt = tickCnt + 9'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            intCnt <= 32'h0;
            actN <= 4'h0;
            actSel <= `PMCA_QTY_POWER;
            tickCnt <= 9'h0;
            acc <= 25'h0;
            outReg <= 16'h0000;
            newData <= 1'b0;
        end else begin
            intCnt <= next_intCnt;
            actN <= next_actN;
            actSel <= next_actSel;
            tickCnt <= next_tickCnt;
            acc <= next_acc;
            outReg <= next_outReg;
            newData <= next_newData;
        end
    end

    // ==========================================================
    // alert pin
    logic dataPending, next_dataPending;
    logic overThreshold;
    logic next_alertOe_n;

    // output bits 15:2 against the unsigned threshold placed at weight 4
    assign overThreshold = $signed(outReg[15:2]) >
        $signed({7'h00, cfgWord[`PMCA_THR_MSB:`PMCA_THR_LSB]});

    always_comb begin
        // a new result arriving with the read wins over the release
        next_dataPending = newData || (dataPending && !outRead);
        if (cfgWord[`PMCA_ALERT_MODE_BIT]) begin
            next_alertOe_n = !overThreshold;
        end else begin
            next_alertOe_n = !next_dataPending;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataPending <= 1'b0;
            alertOe_n <= 1'b1;
            alertOut <= 1'b0;
            shutdownMode <= 1'b0;
        end else begin
            dataPending <= next_dataPending;
            alertOe_n <= next_alertOe_n;
            alertOut <= 1'b0;
            shutdownMode <= cfgWord[`PMCA_SHUTDOWN_BIT];
        end
    end

endmodule : pmca_power_monitor

//--- hw/pmca_regs.svh
// offsets, field positions, reset values and timing counts of the power monitor config block
`ifndef PMCA_REGS_SVH
`define PMCA_REGS_SVH

// command codes seen on the serial bus
`define PMCA_CMD_CONFIG 8'hd0
`define PMCA_CMD_READ_VOLTAGE 8'h8b
`define PMCA_CMD_READ_CURRENT 8'h8c
`define PMCA_CMD_READ_POWER 8'h96

// configuration register layout
`define PMCA_CFG_RESET 16'h0000
`define PMCA_AVG_MSB 3
`define PMCA_AVG_LSB 0
`define PMCA_SHUTDOWN_BIT 4
`define PMCA_EXTERNAL_CLOCK_INPUT_BIT 5
`define PMCA_SEL_MSB 7
`define PMCA_SEL_LSB 6
`define PMCA_ALERT_MODE_BIT 8
`define PMCA_THR_MSB 15
`define PMCA_THR_LSB 9
`define PMCA_AVG_MAX 4'h8

// quantity select encodings
`define PMCA_QTY_POWER 2'h0
`define PMCA_QTY_VOLTAGE 2'h1
`define PMCA_QTY_CURRENT 2'h2

// default slave address
`define PMCA_SLAVE_ADDR 7'h70

// averaging time base: one millisecond
`define PMCA_MS_TIME_NS 1000000
`define PMCA_REF_CLK_PERIOD_NS 40
`define PMCA_INT_MS_CYCLES (`PMCA_MS_TIME_NS / `PMCA_REF_CLK_PERIOD_NS)
`define PMCA_EXT_CLK_PERIOD_NS 32
`define PMCA_EXT_MS_CYCLES (`PMCA_MS_TIME_NS / `PMCA_EXT_CLK_PERIOD_NS)

`endif
